// >>> logic/csq_qualifier.sv
// conditional search qualifier with reset/presence handshake
// Operation
// - conditional search runs only when condition true
// - condition comes from five select bits
// - select bits reset to all ones
// - status write updates select bits persistently
// - channel code none, A, B, or OR
// - both channels ORed then compared
// - source code latch, flip-flop, pin level
// - reserved source: polarity zero always, one never
// - no channel: polarity zero always answers
// - qualify when source equals polarity
// - sample source at command byte end
// - edge sets activity latch, holds value
// - latch cleared by request or power-up
// - single-channel parts read channel B zero
// - device only starts presence pulse
// - presence wait 15-60 us, low 60-240 us
// - search bit, complement, then master bit
// - channel B presence bit reflects existence
`timescale 1ns/1ps
module csq_qualifier
   import csq_pkg::*;
#(
   parameter bit HAS_CH_B = 1'b1,
   parameter int RESET_LOW_CYCLES = RESET_LOW_CYC,
   parameter int PRES_WAIT_CYCLES = PRES_WAIT_CYC,
   parameter int PRES_LOW_CYCLES = PRES_LOW_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // data line, open drain
   input wire logic DQ_IN,
   output logic DQ_OUT,
   output logic DQ_OE,
   // command decoder side
   input wire logic CMD_DONE,
   input wire logic [7:0] CMD_BYTE,
   input wire logic STATUS_WR,
   input wire logic [2:0] STATUS_ADDR,
   input wire logic [7:0] STATUS_DATA,
   input wire logic LATCH_CLEAR_REQUEST,
   input wire logic SEARCH_DONE,
   // channel sources
   input wire logic [1:0] CHANNEL_FF,
   input wire logic OUTPUT_PIN_A,
   input wire logic OUTPUT_PIN_B,
   // results
   output logic SEARCH_ENABLE,
   output logic [4:0] SEARCH_SELECT,
   output logic [1:0] ACTIVITY_LATCH,
   output logic [1:0] PIN_LEVEL,
   output logic CHANNEL_B_PRESENT
);
   csq_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [4:0] sel, next_sel;
   logic part_ok, next_part_ok;
   logic dq_s1, dq_s2, dq_prev;
   logic [1:0] latch_w, level_w, pin_w;
   logic [1:0] src_val;
   logic chan_val, cond_true, is_search, is_cond;
   logic [1:0] src_code, ch_code;
   logic line_low_long;

   // channel b input forced low on single-channel parts
   assign pin_w = {HAS_CH_B ? OUTPUT_PIN_B : 1'b0, OUTPUT_PIN_A};

   // activity latches
   csq_edge_latch #(.CHANNELS(2)) u_latch (
      .clk(CLK),
      .rst(RST),
      .pin_raw(pin_w),
      .clear(LATCH_CLEAR_REQUEST),
      .pin_level(level_w),
      .latch(latch_w)
   );

   // select field decode
   assign src_code = {sel[SRC_HI_BIT], sel[SRC_LO_BIT]};
   assign ch_code = {sel[CH_HI_BIT], sel[CH_LO_BIT]};
   assign is_search = (CMD_BYTE == CMD_SEARCH);
   assign is_cond = (CMD_BYTE == CMD_COND_SEARCH);

   // per-channel source pick
   always_comb begin
      case (src_code)
         SRC_LATCH: src_val = latch_w;
         SRC_FF: src_val = {HAS_CH_B ? CHANNEL_FF[1] : 1'b0, CHANNEL_FF[0]};
         SRC_PIN: src_val = level_w;
         default: src_val = 2'b00;
      endcase
   end

   // channel pick and qualification
   always_comb begin
      case (ch_code)
         CH_A: chan_val = src_val[0];
         CH_B: chan_val = src_val[1];
         CH_AB: chan_val = src_val[0] | src_val[1];
         default: chan_val = 1'b0;
      endcase
      if (src_code == SRC_RSVD || ch_code == CH_NONE) begin
         cond_true = !sel[POL_BIT];
      end else begin
         cond_true = (chan_val == sel[POL_BIT]);
      end
   end

   assign line_low_long = (state != ST_WAIT) && (state != ST_PRES) && !dq_s2
      && (cnt >= CNT_W'(RESET_LOW_CYCLES));

   // next state of link, select byte, participation
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sel = sel;
      next_part_ok = part_ok;
      if (STATUS_WR && STATUS_ADDR == SEL_REG_ADDR) begin
         next_sel = STATUS_DATA[SEL_BITS-1:0];
      end
      case (state)
         ST_IDLE, ST_SESS: begin
            // count low time to spot a reset pulse
            next_cnt = dq_s2 ? '0 : (cnt == '1 ? cnt : cnt + 1'b1);
            if (dq_s2 && !dq_prev && cnt >= CNT_W'(RESET_LOW_CYCLES)) begin
               next_state = ST_WAIT;
               next_cnt = '0;
               next_part_ok = 1'b0;
            end
            if (state == ST_SESS && CMD_DONE) begin
               // sampled once at command byte end
               next_part_ok = is_search || (is_cond && cond_true);
            end
            if (state == ST_SESS && SEARCH_DONE) begin
               next_part_ok = 1'b0;
            end
         end
         ST_WAIT: begin
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_W'(PRES_WAIT_CYCLES - 1)) begin
               next_state = ST_PRES;
               next_cnt = '0;
            end
         end
         ST_PRES: begin
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_W'(PRES_LOW_CYCLES - 1)) begin
               next_state = ST_SESS;
               next_cnt = '0;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt = '0;
         end
      endcase
   end

   // registers; select bits power up as ones
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state <= ST_IDLE;
         cnt <= '0;
         sel <= SEL_RESET;
         part_ok <= 1'b0;
         dq_s1 <= 1'b1;
         dq_s2 <= 1'b1;
         dq_prev <= 1'b1;
         DQ_OUT <= 1'b0;
         DQ_OE <= 1'b0;
         SEARCH_ENABLE <= 1'b0;
         SEARCH_SELECT <= SEL_RESET;
         ACTIVITY_LATCH <= '0;
         PIN_LEVEL <= '0;
         CHANNEL_B_PRESENT <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sel <= next_sel;
         part_ok <= next_part_ok;
         dq_s1 <= DQ_IN;
         dq_s2 <= dq_s1;
         dq_prev <= dq_s2;
         DQ_OUT <= 1'b0;
         DQ_OE <= (next_state == ST_PRES);
         SEARCH_ENABLE <= next_part_ok;
         SEARCH_SELECT <= next_sel;
         ACTIVITY_LATCH <= latch_w;
         PIN_LEVEL <= level_w;
         CHANNEL_B_PRESENT <= HAS_CH_B;
      end
   end

   // presence pulse sequence
   sequence s_reset_end;
      state == ST_WAIT && cnt == '0;
   endsequence
   sequence s_presence;
      state == ST_PRES && DQ_OE;
   endsequence

   AST_ONLY_PRESENCE_DRIVES: assert property (@(posedge CLK) disable iff (RST)
      DQ_OE |-> state == ST_PRES)
      else $error("line driven outside presence");
   AST_PRESENCE_WAIT: assert property (@(posedge CLK) disable iff (RST)
      s_reset_end |-> !DQ_OE [*8])
      else $error("presence started too early");
   AST_PRESENCE_END: assert property (@(posedge CLK) disable iff (RST)
      (s_presence and (cnt == CNT_W'(PRES_LOW_CYCLES - 1))) |=> !DQ_OE)
      else $error("presence pulse too long");
   AST_SEL_POWERUP: assert property (@(posedge CLK)
      $fell(RST) |-> sel == SEL_RESET)
      else $error("select bits not all ones");
   AST_SEL_WRITE: assert property (@(posedge CLK) disable iff (RST)
      (STATUS_WR && STATUS_ADDR == SEL_REG_ADDR) |=> sel == $past(STATUS_DATA[4:0]))
      else $error("select write lost");
   AST_RSVD_POL1: assert property (@(posedge CLK) disable iff (RST)
      (state == ST_SESS && CMD_DONE && is_cond && src_code == SRC_RSVD
       && sel[POL_BIT] && !SEARCH_DONE) |=> !part_ok)
      else $error("reserved code answered");
   AST_NONE_POL0: assert property (@(posedge CLK) disable iff (RST)
      (state == ST_SESS && CMD_DONE && is_cond && ch_code == CH_NONE
       && !sel[POL_BIT] && !SEARCH_DONE && !line_low_long) |=> part_ok)
      else $error("unconditional search missed");
   AST_OR_POL0: assert property (@(posedge CLK) disable iff (RST)
      (state == ST_SESS && CMD_DONE && is_cond && ch_code == CH_AB && src_code != SRC_RSVD
       && !sel[POL_BIT] && (src_val != 2'b00)) |=> !part_ok)
      else $error("or condition mis-qualified");
   AST_DROP_AFTER: assert property (@(posedge CLK) disable iff (RST)
      (state == ST_SESS && SEARCH_DONE) |=> !part_ok)
      else $error("still participating after search");
endmodule

// >>> logic/csq_pkg.sv
// constants and types for the conditional search qualifier
package csq_pkg;
   // command codes
   localparam logic [7:0] CMD_COND_SEARCH = 8'hEC;
   localparam logic [7:0] CMD_SEARCH = 8'hF0;
   // status memory location of the select byte
   localparam logic [2:0] SEL_REG_ADDR = 3'h7;
   // select bit positions
   localparam int POL_BIT = 0;
   localparam int SRC_LO_BIT = 1;
   localparam int SRC_HI_BIT = 2;
   localparam int CH_LO_BIT = 3;
   localparam int CH_HI_BIT = 4;
   localparam int SEL_BITS = 5;
   localparam logic [4:0] SEL_RESET = 5'h1F;
   // channel info bit for channel b presence
   localparam int INFO_CHB_BIT = 6;
   // source codes
   localparam logic [1:0] SRC_RSVD = 2'h0;
   localparam logic [1:0] SRC_LATCH = 2'h1;
   localparam logic [1:0] SRC_FF = 2'h2;
   localparam logic [1:0] SRC_PIN = 2'h3;
   // channel codes
   localparam logic [1:0] CH_NONE = 2'h0;
   localparam logic [1:0] CH_A = 2'h1;
   localparam logic [1:0] CH_B = 2'h2;
   localparam logic [1:0] CH_AB = 2'h3;
   // timing
   localparam int CLK_MHZ = 50;
   localparam int RESET_LOW_US = 480;
   localparam int PRES_WAIT_MIN_US = 15;
   localparam int PRES_WAIT_MAX_US = 60;
   localparam int PRES_LOW_MIN_US = 60;
   localparam int PRES_LOW_MAX_US = 240;
   // reset detection uses the least reset time, rounded up
   localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
   // wait and low time centred inside their windows
   localparam int PRES_WAIT_CYC = (PRES_WAIT_MIN_US + PRES_WAIT_MAX_US) * CLK_MHZ / 2;
   localparam int PRES_LOW_CYC = (PRES_LOW_MIN_US + PRES_LOW_MAX_US) * CLK_MHZ / 2;
   localparam int CNT_W = 16;
   // link states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_PRES = 4'b0100,
      ST_SESS = 4'b1000
   } csq_state_t;
endpackage

// >>> logic/csq_edge_latch.sv
// per-channel activity latch with pin synchroniser and edge detector
`timescale 1ns/1ps
module csq_edge_latch
   import csq_pkg::*;
#(
   parameter int CHANNELS = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins and control
   input wire logic [CHANNELS-1:0] pin_raw,
   input wire logic clear,
   // state
   output logic [CHANNELS-1:0] pin_level,
   output logic [CHANNELS-1:0] latch
);
   logic [CHANNELS-1:0] sync1;
   logic [CHANNELS-1:0] sync2;
   logic [CHANNELS-1:0] prev;
   logic [CHANNELS-1:0] next_latch;
   // edges ignored until the sync chain holds real pin levels
   logic [2:0] primed;

   // next latch values, edge set wins over clear
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         always_comb begin
            next_latch[g] = clear ? 1'b0 : latch[g];
            if (primed[2] && sync2[g] != prev[g]) begin
               next_latch[g] = 1'b1;
            end
         end
      end
   endgenerate

   // registers; power-up clears the latches
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
         primed <= '0;
         latch <= '0;
      end else begin
         primed <= {primed[1:0], 1'b1};
         sync1 <= pin_raw;
         sync2 <= sync1;
         prev <= sync2;
         latch <= next_latch;
      end
   end
   assign pin_level = prev;

   AST_EDGE_SETS: assert property (@(posedge clk) disable iff (rst)
      (primed[2] && sync2[0] != prev[0]) |=> latch[0])
      else $error("edge did not set latch");
   AST_LATCH_HOLDS: assert property (@(posedge clk) disable iff (rst)
      (latch[0] && !clear) |=> latch[0])
      else $error("latch dropped without clear");
endmodule

// >>> testbench/csq_master_model.sv
// bus master model that owns the reset pulse on the open-drain data line
`timescale 1ns/1ps
module csq_master_model (
   // clock and device pull-down
   input wire logic clk,
   input wire logic dq_oe,
   // resolved line level
   output logic dq_in
);
   logic pull_low = 1'b0;
   // pull-up resolves the wired line when nobody pulls low
   assign dq_in = ~(pull_low | dq_oe);
   // master starts the reset, device only answers with presence
   task automatic reset_pulse(input int cycles);
      @(posedge clk);
      #2 pull_low = 1'b1;
      repeat (cycles) @(posedge clk);
      #2 pull_low = 1'b0;
   endtask
endmodule

// >>> testbench/conditional_search_qualifier_tb.sv
// self-checking bench for the conditional search qualifier
`timescale 1ns/1ps
module conditional_search_qualifier_tb;
   import csq_pkg::*;
   localparam int RL = 20;
   localparam int PW = 10;
   localparam int PL = 15;
   logic CLK = 0, RST = 1, CMD_DONE = 0, STATUS_WR = 0, LATCH_CLEAR_REQUEST = 0, SEARCH_DONE = 0;
   logic [7:0] CMD_BYTE = 8'h00, STATUS_DATA = 8'h00, rnd = 8'h1E;
   logic [2:0] STATUS_ADDR = 3'h0;
   logic [1:0] CHANNEL_FF = 2'h0, pins = 2'h0, exp_lat = 2'h0, ACTIVITY_LATCH, PIN_LEVEL;
   logic DQ_IN, DQ_OUT, DQ_OE, SEARCH_ENABLE, CHANNEL_B_PRESENT, exp_en;
   logic [4:0] SEARCH_SELECT, sel;
   int n_errors = 0, n_compared = 0, cyc = 0, w = 0;
   // clock and cycle ceiling
   always #10 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         report_and_stop();
      end
   end
   csq_master_model m_u (.clk(CLK), .dq_oe(DQ_OE), .dq_in(DQ_IN));
   csq_qualifier #(.HAS_CH_B(1'b1), .RESET_LOW_CYCLES(RL), .PRES_WAIT_CYCLES(PW),
      .PRES_LOW_CYCLES(PL)) dut_u (.CLK(CLK), .RST(RST), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT),
      .DQ_OE(DQ_OE), .CMD_DONE(CMD_DONE), .CMD_BYTE(CMD_BYTE), .STATUS_WR(STATUS_WR),
      .STATUS_ADDR(STATUS_ADDR), .STATUS_DATA(STATUS_DATA),
      .LATCH_CLEAR_REQUEST(LATCH_CLEAR_REQUEST), .SEARCH_DONE(SEARCH_DONE),
      .CHANNEL_FF(CHANNEL_FF), .OUTPUT_PIN_A(pins[0]), .OUTPUT_PIN_B(pins[1]),
      .SEARCH_ENABLE(SEARCH_ENABLE), .SEARCH_SELECT(SEARCH_SELECT),
      .ACTIVITY_LATCH(ACTIVITY_LATCH), .PIN_LEVEL(PIN_LEVEL),
      .CHANNEL_B_PRESENT(CHANNEL_B_PRESENT));
   // random source
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   // expected participation from select code and source values
   function automatic logic qual(input logic [4:0] s, input logic [1:0] lat, ff, pin);
      logic [1:0] v;
      v = (s[2:1] == SRC_LATCH) ? lat : (s[2:1] == SRC_FF) ? ff : pin;
      if (s[2:1] == SRC_RSVD || s[4:3] == CH_NONE) return !s[0];
      if (s[4:3] == CH_A) return v[0] == s[0];
      if (s[4:3] == CH_B) return v[1] == s[0];
      return (v[0] | v[1]) == s[0];
   endfunction
   task automatic tick();
      @(posedge CLK);
      #2;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      STATUS_WR = 1'b1;
      STATUS_ADDR = a;
      STATUS_DATA = d;
      tick();
      STATUS_WR = 1'b0;
      tick();
   endtask
   // reset pulse, then measure presence delay and width
   task automatic link_reset();
      m_u.reset_pulse(25);
      w = 0;
      while (DQ_OE !== 1'b1 && w < 100) begin
         tick();
         w++;
      end
      chk(8'(w >= PW && w <= PW + 5), 8'h01);
      w = 0;
      while (DQ_OE === 1'b1 && w < 300) begin
         tick();
         w++;
      end
      chk(8'(w), 8'(PL));
      chk(8'(DQ_OUT), 8'h00);
   endtask
   task automatic report_and_stop();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // main sequence: reset values, short pulse, then every select code
   initial begin
      repeat (8) tick();
      RST = 1'b0;
      tick();
      tick();
      chk(8'(SEARCH_SELECT), 8'(SEL_RESET));
      chk(8'(CHANNEL_B_PRESENT), 8'h01);
      chk(8'(ACTIVITY_LATCH), 8'h00);
      m_u.reset_pulse(8);
      w = 0;
      repeat (40) begin
         tick();
         w += (DQ_OE !== 1'b0);
      end
      chk(8'(w), 8'h00);
      for (int i = 0; i < 48; i++) begin
         sel = (i < 32) ? 5'(i) : rnd[4:0];
         rnd = lfsr(rnd);
         link_reset();
         wr(SEL_REG_ADDR, {3'h0, sel});
         wr(3'h6, {3'h0, ~sel});
         chk(8'(SEARCH_SELECT), 8'(sel));
         if (rnd[7]) begin
            LATCH_CLEAR_REQUEST = 1'b1;
            tick();
            LATCH_CLEAR_REQUEST = 1'b0;
            exp_lat = 2'h0;
         end
         // transistors kept off while the latch is the source
         CHANNEL_FF = (sel[2:1] == SRC_LATCH) ? 2'h3 : rnd[1:0];
         exp_lat = exp_lat | (pins ^ rnd[3:2]);
         pins = rnd[3:2];
         rnd = lfsr(rnd);
         repeat (6) tick();
         chk(8'(ACTIVITY_LATCH), 8'(exp_lat));
         chk(8'(PIN_LEVEL), 8'(pins));
         CMD_BYTE = (i > 31 && i % 4 == 3) ? CMD_SEARCH : CMD_COND_SEARCH;
         exp_en = (CMD_BYTE == CMD_SEARCH) || qual(sel, exp_lat, CHANNEL_FF, pins);
         CMD_DONE = 1'b1;
         tick();
         CMD_DONE = 1'b0;
         CHANNEL_FF = ~CHANNEL_FF;
         chk(8'(SEARCH_ENABLE), 8'(exp_en));
         tick();
         chk(8'(SEARCH_ENABLE), 8'(exp_en));
         SEARCH_DONE = 1'b1;
         tick();
         SEARCH_DONE = 1'b0;
         tick();
         chk(8'(SEARCH_ENABLE), 8'h00);
      end
      report_and_stop();
   end
endmodule
